// file: grpm_asserts.sv
`timescale 1ns/1ps
module grpm_asserts (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        master_reset_n,
  input wire logic        main_supply_rail,
  input wire logic        backup_supply_input,
  input wire logic        test_req,
  input wire logic        test_req_text,
  input wire logic        test_rpt,
  input wire logic [15:0] test_rpt_msg,
  input wire logic        test_pass
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  rpt_code_a: assert property (test_rpt |-> test_rpt_msg == 16'h044C)
    else $error("report code wrong");
  rpt_pulse_a: assert property (test_rpt |=> !test_rpt)
    else $error("report longer than one cycle");
  rpt_cause_a: assert property (test_rpt |-> (test_req || test_req_text))
    else $error("report without request");
  req_hold_a: assert property ((test_req && !test_rpt) |=> test_req)
    else $error("request dropped before report");
  req_clear_a: assert property (test_rpt |-> ##[1:4] !(test_req || test_req_text))
    else $error("request not released after report");
  rst_main_a: assert property (!main_supply_rail |=> !master_reset_n)
    else $error("reset line high without main power");
  rst_min_a: assert property ($fell(master_reset_n) |-> !master_reset_n[*8] ##1 !master_reset_n[*7])
    else $error("reset low pulse too short");
  rpt_power_a: assert property (test_rpt |-> master_reset_n && main_supply_rail)
    else $error("report outside operate");
  pass_stable_a: assert property (!test_rpt |-> $stable(test_pass))
    else $error("pass flag moved without report");
  cover property (test_rpt && test_req);
  cover property (test_rpt && test_req_text);
  cover property ($rose(master_reset_n));
endmodule : grpm_asserts

// file: grpm_defines.svh
// Functional notes
// - host holds reset low at least 150 ns
// - host releases reset with or after power
// - reset low keeps receiver in low power
// - low power: radio part on, full radio off, retention, clock
// - release: radio on, system reset, then operate
// - three power modes: off, operate, keep-alive
// - operate: main rail powered, whatever the backup or reset level
// - main lost with backup: keep-alive mode
// - reset line driven directly, no resistors
// - test request 1300, report 1100, text too
// - 3d with four satellites, else 2d; the code also gives 2d whenever force_2d_in is set
// - start type chosen from stored data
// - corrections only via auxiliary port
// - main lost: memory and clock on backup
`ifndef GRPM_DEFINES_SVH
`define GRPM_DEFINES_SVH
`define GRPM_CLK_PERIOD_NS    10
`define GRPM_RST_MIN_NS       150
`define GRPM_RST_MIN_CYC      ((`GRPM_RST_MIN_NS + `GRPM_CLK_PERIOD_NS - 1) / `GRPM_CLK_PERIOD_NS)
`define GRPM_RF_SETTLE_CYC    8
`define GRPM_SYSRST_CYC       4
`define GRPM_MIN_SATS_3D      4'h4
`define GRPM_MSG_TEST_REQ     16'h0514
`define GRPM_MSG_TEST_RPT     16'h044C
`endif

// file: grpm_host.sv
`timescale 1ns/1ps
`include "grpm_defines.svh"
module grpm_host (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  grpm_if.host             link,
  input  wire logic        main_on_in,
  input  wire logic        backup_on_in,
  input  wire logic        hold_reset_in,
  input  wire logic        test_in,
  input  wire logic        test_text_in,
  output logic             test_done_out,
  output logic             test_pass_out,
  output logic             busy_out
);
  logic [4:0] low_cnt;
  logic       rst_n;
  logic       pend, pend_txt;

  assign link.main_supply_rail    = main_on_in;
  assign link.backup_supply_input = backup_on_in;
  assign link.master_reset_n      = rst_n;
  assign link.test_req            = pend && !pend_txt;
  assign link.test_req_text       = pend && pend_txt;
  assign busy_out                 = !rst_n || pend;

  // reset line drive
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rst_n   <= 1'b0;
      low_cnt <= 5'h00;
    end else if (!main_on_in || hold_reset_in) begin
      rst_n   <= 1'b0;
      low_cnt <= 5'h00;
    end else if (!rst_n) begin
      if (low_cnt >= 5'(`GRPM_RST_MIN_CYC)) rst_n <= 1'b1;
      else low_cnt <= low_cnt + 5'h01;
    end
  end

  // test request until report
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pend          <= 1'b0;
      pend_txt      <= 1'b0;
      test_done_out <= 1'b0;
      test_pass_out <= 1'b0;
    end else begin
      test_done_out <= 1'b0;
      if (pend && link.test_rpt && link.test_rpt_msg == `GRPM_MSG_TEST_RPT) begin
        pend          <= 1'b0;
        test_done_out <= 1'b1;
        test_pass_out <= link.test_pass;
      end else if (!pend && rst_n && (test_in || test_text_in)) begin
        pend     <= 1'b1;
        pend_txt <= !test_in;
      end
    end
  end
endmodule : grpm_host

// file: grpm_if.sv
`timescale 1ns/1ps
interface grpm_if;
  logic        master_reset_n;
  logic        main_supply_rail;
  logic        backup_supply_input;
  logic        test_req;
  logic        test_req_text;
  logic        test_rpt;
  logic [15:0] test_rpt_msg;
  logic        test_pass;
  modport receiver (input master_reset_n, main_supply_rail, backup_supply_input, test_req, test_req_text,
                    output test_rpt, test_rpt_msg, test_pass);
  modport host (output master_reset_n, main_supply_rail, backup_supply_input, test_req, test_req_text,
                input test_rpt, test_rpt_msg, test_pass);
endinterface : grpm_if

// file: grpm_pkg.sv
package grpm_pkg;
  typedef enum logic [1:0] {GRPM_OFF, GRPM_OPERATE, GRPM_KEEP_ALIVE} grpm_mode_type;
  typedef enum logic [1:0] {GRPM_WARM, GRPM_INIT, GRPM_COLD, GRPM_FROZEN} grpm_start_type;
  typedef enum logic [1:0] {GRPM_PROTO_BIN, GRPM_PROTO_TEXT} grpm_proto_type;
endpackage : grpm_pkg

// file: grpm_receiver.sv
`timescale 1ns/1ps
`include "grpm_defines.svh"
module grpm_receiver (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  grpm_if.receiver                     link,
  input  wire logic [3:0]              sats_tracked_in,
  input  wire logic                    force_2d_in,
  input  wire logic                    ephem_valid_in,
  input  wire logic                    pos_time_valid_in,
  input  wire logic                    almanac_valid_in,
  input  wire logic                    health_ok_in,
  input  wire logic                    aux_dgps_valid_in,
  input  wire logic                    host_dgps_valid_in,
  output logic                         rf_partial_on_out,
  output logic                         rf_full_on_out,
  output logic                         sram_retention_out,
  output logic                         rtc_on_out,
  output logic                         mem_on_backup_out,
  output logic                         sys_reset_out,
  output logic                         low_power_out,
  output grpm_pkg::grpm_mode_type      mode_out,
  output grpm_pkg::grpm_start_type     start_type_out,
  output logic                         nav_3d_out,
  output logic                         dgps_accept_out
);
  typedef enum {ST_HELD, ST_RF_UP, ST_SYSRST, ST_RUN} grpm_seq_type;
  grpm_seq_type seq;
  logic       rst_meta, rst_sync, main_meta, main_sync, bak_meta, bak_sync;
  logic       req_meta, req_sync, req_prev, txt_meta, txt_sync, txt_prev;
  logic [3:0] cnt;

  function automatic grpm_pkg::grpm_start_type pick_start(input logic e, input logic p, input logic a);
    if (e) pick_start = grpm_pkg::GRPM_WARM;
    else if (p) pick_start = grpm_pkg::GRPM_INIT;
    else if (a) pick_start = grpm_pkg::GRPM_COLD;
    else pick_start = grpm_pkg::GRPM_FROZEN;
  endfunction : pick_start

  // rising edge of a synchronised level
  function automatic logic rise_seen(input logic now_lvl, input logic old_lvl);
    rise_seen = now_lvl && !old_lvl;
  endfunction : rise_seen

  // main present while the sequence still holds
  function automatic logic held_on_main(input logic main_lvl, input grpm_seq_type st);
    held_on_main = main_lvl && st == ST_HELD;
  endfunction : held_on_main

  // reset pin synchroniser
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= link.master_reset_n;
      rst_sync <= rst_meta;
    end
  end

  // main rail synchroniser
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      main_meta <= 1'b0;
      main_sync <= 1'b0;
    end else begin
      main_meta <= link.main_supply_rail;
      main_sync <= main_meta;
    end
  end

  // backup rail synchroniser
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bak_meta <= 1'b0;
      bak_sync <= 1'b0;
    end else begin
      bak_meta <= link.backup_supply_input;
      bak_sync <= bak_meta;
    end
  end

  // binary test request synchroniser and history
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      req_meta <= link.test_req;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // text test request synchroniser and history
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      txt_meta <= 1'b0;
      txt_sync <= 1'b0;
      txt_prev <= 1'b0;
    end else begin
      txt_meta <= link.test_req_text;
      txt_sync <= txt_meta;
      txt_prev <= txt_sync;
    end
  end

  // reset release sequence
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      seq <= ST_HELD;
      cnt <= 4'h0;
    end else if (!rst_sync || !main_sync) begin
      seq <= ST_HELD;
      cnt <= 4'h0;
    end else begin
      case (seq)
        ST_HELD: begin
          seq <= ST_RF_UP;
          cnt <= 4'h0;
        end
        ST_RF_UP: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'(`GRPM_RF_SETTLE_CYC - 1)) begin
            seq <= ST_SYSRST;
            cnt <= 4'h0;
          end
        end
        ST_SYSRST: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'(`GRPM_SYSRST_CYC - 1)) seq <= ST_RUN;
        end
        ST_RUN: seq <= ST_RUN;
        default: seq <= ST_HELD;
      endcase
    end
  end

  // power mode
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mode_out <= grpm_pkg::GRPM_OFF;
    end else if (main_sync) begin
      mode_out <= grpm_pkg::GRPM_OPERATE;
    end else if (bak_sync) begin
      mode_out <= grpm_pkg::GRPM_KEEP_ALIVE;
    end else begin
      mode_out <= grpm_pkg::GRPM_OFF;
    end
  end

  // memory and clock supply
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sram_retention_out <= 1'b0;
      rtc_on_out         <= 1'b0;
      mem_on_backup_out  <= 1'b0;
    end else begin
      mem_on_backup_out  <= !main_sync && bak_sync;
      rtc_on_out         <= main_sync || bak_sync;
      sram_retention_out <= held_on_main(main_sync, seq) || (!main_sync && bak_sync);
    end
  end

  // radio supply
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rf_partial_on_out <= 1'b0;
      rf_full_on_out    <= 1'b0;
    end else begin
      rf_partial_on_out <= main_sync;
      rf_full_on_out    <= main_sync && seq != ST_HELD;
    end
  end

  // low power state and system reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      low_power_out <= 1'b0;
      sys_reset_out <= 1'b1;
    end else begin
      low_power_out <= held_on_main(main_sync, seq);
      sys_reset_out <= seq != ST_RUN;
    end
  end

  // navigation dimension
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      nav_3d_out <= 1'b0;
    end else begin
      nav_3d_out <= seq == ST_RUN && !force_2d_in && sats_tracked_in >= `GRPM_MIN_SATS_3D;
    end
  end

  // correction acceptance
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dgps_accept_out <= 1'b0;
    end else begin
      dgps_accept_out <= seq == ST_RUN && aux_dgps_valid_in && !host_dgps_valid_in;
    end
  end

  // start type, latched during system reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      start_type_out <= grpm_pkg::GRPM_FROZEN;
    end else if (seq == ST_SYSRST) begin
      start_type_out <= pick_start(ephem_valid_in, pos_time_valid_in, almanac_valid_in);
    end
  end

  // built-in test
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      link.test_rpt     <= 1'b0;
      link.test_rpt_msg <= 16'h0000;
      link.test_pass    <= 1'b0;
    end else begin
      link.test_rpt <= 1'b0;
      if (seq == ST_RUN && (rise_seen(req_sync, req_prev) || rise_seen(txt_sync, txt_prev))) begin
        link.test_rpt     <= 1'b1;
        link.test_rpt_msg <= `GRPM_MSG_TEST_RPT;
        link.test_pass    <= health_ok_in;
      end
    end
  end
endmodule : grpm_receiver

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_in = 0, rstn_in = 0, main_on = 0, bk_on = 0, hold = 0, t_bin = 0, t_txt = 0;
  logic f2d = 0, eph = 0, pos = 0, alm = 0, hok = 1, aux = 0, hst = 0;
  logic [3:0] sats = 4'h0;
  logic rfp, rff, sret, rtc, mbk, srst, lowp, n3d, dacc, tdone, tpass, busy;
  grpm_pkg::grpm_mode_type  mode;
  grpm_pkg::grpm_start_type st;
  int bad_count = 0, n_tests = 0;
  typedef struct {logic [3:0] s; logic f, e, p, a, x3; grpm_pkg::grpm_start_type xs;} grpm_row_type;
  grpm_row_type rows [5] = '{'{4'h4, 0, 1, 1, 1, 1, grpm_pkg::GRPM_WARM}, '{4'h3, 0, 0, 1, 1, 0, grpm_pkg::GRPM_INIT},
    '{4'hF, 1, 0, 0, 1, 0, grpm_pkg::GRPM_COLD}, '{4'h5, 0, 0, 0, 0, 1, grpm_pkg::GRPM_FROZEN},
    '{4'h0, 0, 0, 0, 0, 0, grpm_pkg::GRPM_FROZEN}};
  always #5 clk_in = ~clk_in;
  grpm_if link ();
  grpm_receiver u_grpm_receiver (.clk_in(clk_in), .rstn_in(rstn_in), .link(link.receiver), .sats_tracked_in(sats),
    .force_2d_in(f2d), .ephem_valid_in(eph), .pos_time_valid_in(pos), .almanac_valid_in(alm), .health_ok_in(hok),
    .aux_dgps_valid_in(aux), .host_dgps_valid_in(hst), .rf_partial_on_out(rfp), .rf_full_on_out(rff),
    .sram_retention_out(sret), .rtc_on_out(rtc), .mem_on_backup_out(mbk), .sys_reset_out(srst),
    .low_power_out(lowp), .mode_out(mode), .start_type_out(st), .nav_3d_out(n3d), .dgps_accept_out(dacc));
  grpm_host u_grpm_host (.clk_in(clk_in), .rstn_in(rstn_in), .link(link.host), .main_on_in(main_on),
    .backup_on_in(bk_on), .hold_reset_in(hold), .test_in(t_bin), .test_text_in(t_txt),
    .test_done_out(tdone), .test_pass_out(tpass), .busy_out(busy));
  grpm_asserts u_grpm_asserts (.clk_in(clk_in), .rstn_in(rstn_in), .master_reset_n(link.master_reset_n),
    .main_supply_rail(link.main_supply_rail), .backup_supply_input(link.backup_supply_input),
    .test_req(link.test_req), .test_req_text(link.test_req_text), .test_rpt(link.test_rpt),
    .test_rpt_msg(link.test_rpt_msg), .test_pass(link.test_pass));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task run_up;
    for (int i = 0; i < 80 && srst !== 1'b0; i++) @(negedge clk_in);
  endtask : run_up
  task do_test(input logic txt);
    if (txt) t_txt = 1; else t_bin = 1;
    for (int i = 0; i < 40 && tdone !== 1'b1; i++) @(negedge clk_in);
    chk("test_done", tdone, 1);
    chk("test_pass", tpass, hok);
    t_bin = 0;
    t_txt = 0;
    wt(3);
  endtask : do_test
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    #100us;
    bad_count++;
    stop_test;
  end
  initial begin
    wt(10);
    rstn_in = 1;
    wt(2);
    chk("mode_off", mode, grpm_pkg::GRPM_OFF);
    main_on = 1;
    bk_on = 1;
    run_up;
    chk("rf_full", rff, 1);
    chk("sys_reset", srst, 0);
    chk("mode_run", mode, grpm_pkg::GRPM_OPERATE);
    chk("low_power", lowp, 0);
    chk("busy_idle", busy, 0);
    foreach (rows[i]) begin
      {sats, f2d, eph, pos, alm} = {rows[i].s, rows[i].f, rows[i].e, rows[i].p, rows[i].a};
      hold = 1;
      wt(6);
      hold = 0;
      run_up;
      chk("nav_3d", n3d, rows[i].x3);
      chk("start_type", st, rows[i].xs);
    end
    $display("table test done");
    aux = 1;
    wt(3);
    chk("dgps_aux", dacc, 1);
    hst = 1;
    wt(3);
    chk("dgps_host", dacc, 0);
    aux = 0;
    hst = 0;
    do_test(0);
    hok = 0;
    do_test(1);
    $display("test request done");
    hold = 1;
    wt(25);
    chk("hold_low_power", lowp, 1);
    chk("hold_rf_full", rff, 0);
    chk("hold_retention", sret, 1);
    chk("hold_rtc", rtc, 1);
    chk("hold_rf_part", rfp, 1);
    chk("hold_busy", busy, 1);
    hold = 0;
    for (int i = 0; i < 40 && rff !== 1'b1; i++) @(negedge clk_in);
    chk("rf_before_sysrst", srst, 1);
    run_up;
    chk("rerun_sys_reset", srst, 0);
    $display("reset hold done");
    main_on = 0;
    wt(5);
    chk("mode_keep", mode, grpm_pkg::GRPM_KEEP_ALIVE);
    chk("mem_backup", mbk, 1);
    chk("keep_rtc", rtc, 1);
    chk("keep_rf_part", rfp, 0);
    chk("keep_retention", sret, 1);
    bk_on = 0;
    wt(5);
    chk("mode_off_end", mode, grpm_pkg::GRPM_OFF);
    $display("power modes done");
    stop_test;
  end
endmodule : tb
